// ---- status_pkg.sv ----
/*
 Package for the display mode status readback block: command codes,
 status bit positions, reset values and the state and carrier types.
 Assumes nothing of its surroundings.
*/
package status_pkg;

  localparam logic [7:0] CMD_READ_IMAGE_MODE = 8'h0d;
  localparam logic [7:0] CMD_READ_SIGNAL_MODE = 8'h0e;

  localparam int IM_SCROLL_BIT = 7;
  localparam int IM_INVERT_BIT = 5;

  localparam int SM_TE_ON_BIT = 7;
  localparam int SM_TE_MODE_BIT = 6;
  localparam int SM_HSYNC_BIT = 5;
  localparam int SM_VSYNC_BIT = 4;
  localparam int SM_PCLK_BIT = 3;
  localparam int SM_DE_BIT = 2;
  localparam int SM_DSI_ERR_BIT = 0;

  localparam logic [7:0] IMAGE_MODE_RESET = 8'h00;
  localparam logic [7:0] SIGNAL_MODE_RESET = 8'h00;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // Reads before the status byte is presented
  localparam logic [1:0] DUMMY_READS = 2'h1;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_DUMMY = 3'b010,
    RD_STATUS = 3'b100
  } read_state_e;

  // Display state flags sampled into the status bytes
  typedef struct packed {
    logic scroll_on;
    logic invert_on;
    logic te_on;
    logic te_mode2;
    logic hsync_on;
    logic vsync_on;
    logic pclk_on;
    logic de_on;
  } disp_flags_s;

  // Bus strobes from the host
  typedef struct packed {
    logic data_command_select;
    logic read_strobe;
    logic write_strobe;
  } bus_strobes_s;

endpackage

// ---- edge_rise.sv ----
/*
 Rising edge detector for one strobe.
 Assumes the strobe is synchronous to sys_clk.
*/
`timescale 1ns/100ps
module edge_rise
  import status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic level,
  output logic rise
);

  logic level_r;
  logic level_nxt;

  always_comb begin
    level_nxt = level;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      level_r <= 1'b1;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign rise = level & ~level_r;

endmodule

// ---- status_byte.sv ----
/*
 Status byte assembly for both readback commands, with a sticky link
 error flag. Assumes the flags are synchronous to sys_clk.
*/
`timescale 1ns/100ps
module status_byte
  import status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire disp_flags_s flags,
  input wire logic dsi_error,
  output logic [7:0] image_mode,
  output logic [7:0] signal_mode
);

  logic dsi_err_r;
  logic dsi_err_nxt;

  ////////////////////////////////////////////////////////////////////
  // Sticky link error, cleared only by resetn or soft_reset
  always_comb begin
    dsi_err_nxt = dsi_err_r | dsi_error;
    if (soft_reset) begin
      dsi_err_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dsi_err_r <= 1'b0;
    end else begin
      dsi_err_r <= dsi_err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    image_mode = IMAGE_MODE_RESET;
    signal_mode = SIGNAL_MODE_RESET;
    if (!soft_reset) begin
      // RULE3 - scrolling bit
      image_mode[IM_SCROLL_BIT] = flags.scroll_on;
      // RULE4 - inversion bit
      image_mode[IM_INVERT_BIT] = flags.invert_on;
      // RULE10 - tearing line enable
      signal_mode[SM_TE_ON_BIT] = flags.te_on;
      // RULE11 - tearing line mode
      signal_mode[SM_TE_MODE_BIT] = flags.te_mode2;
      // RULE12 - horizontal sync
      signal_mode[SM_HSYNC_BIT] = flags.hsync_on;
      // RULE13 - vertical sync
      signal_mode[SM_VSYNC_BIT] = flags.vsync_on;
      // RULE14 - pixel clock
      signal_mode[SM_PCLK_BIT] = flags.pclk_on;
      // RULE15 - data enable
      signal_mode[SM_DE_BIT] = flags.de_on;
      // RULE16 - error bit low when clean
      // RULE17 - error bit high on error
      signal_mode[SM_DSI_ERR_BIT] = dsi_err_r;
    end
  end

  // RULE17 - error stays reported
  dsi_sticky_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE17
    dsi_error && !soft_reset |=> soft_reset || signal_mode[SM_DSI_ERR_BIT])
    else $error("link error not reported");

endmodule

// ---- display_mode_status_readback.sv ----
/*
 Display mode status readback: decodes the two status read commands
 on the command bus and returns a dummy byte (none in link mode) then the status byte,
 repeating the status byte for further reads.
 Assumes strobes synchronous to sys_clk and a host that keeps the
 command write protocol.
*/
// Behaviour
// RULE1 - host writes 0dh as command
// RULE2 - dummy byte then image status byte
// RULE3 - bit 7 shows vertical scrolling
// RULE4 - bit 5 shows inversion, others reserved
// RULE5 - extra reads repeat the status byte
// RULE6 - link mode skips the dummy byte
// RULE7 - commands accepted in every power state
// RULE8 - image status resets to zero
// RULE9 - host writes 0eh, reads dummy, status
// RULE10 - bit 7 shows tearing line enabled
// RULE11 - bit 6 shows tearing line mode
// RULE12 - bit 5 shows horizontal sync
// RULE13 - bit 4 shows vertical sync
// RULE14 - bit 3 shows pixel clock running
// RULE15 - bit 2 shows data enable
// RULE16 - bit 1 reserved, bit 0 clean
// RULE17 - bit 0 set on link error
// RULE18 - signal status resets to zero
`timescale 1ns/100ps
module display_mode_status_readback
  import status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire bus_strobes_s strobes,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic dsi_mode,
  input wire logic sleep_in,
  input wire disp_flags_s flags,
  input wire logic dsi_error
);

  read_state_e state_r;
  read_state_e state_nxt;
  logic sel_signal_r;
  logic sel_signal_nxt;
  logic [7:0] data_out_r;
  logic [7:0] data_out_nxt;
  logic wr_rise;
  logic rd_rise;
  logic [7:0] image_mode;
  logic [7:0] signal_mode;
  logic cmd_write;
  logic data_read;
  logic is_status_cmd;

  function automatic logic status_cmd(input logic [7:0] code);
    status_cmd = (code == CMD_READ_IMAGE_MODE) || (code == CMD_READ_SIGNAL_MODE);
  endfunction

  ////////////////////////////////////////////////////////////////////
  edge_rise wr_edge (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .level(strobes.write_strobe),
    .rise(wr_rise)
  );

  edge_rise rd_edge (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .level(strobes.read_strobe),
    .rise(rd_rise)
  );

  status_byte status (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .soft_reset(soft_reset),
    .flags(flags),
    .dsi_error(dsi_error),
    .image_mode(image_mode),
    .signal_mode(signal_mode)
  );

  ////////////////////////////////////////////////////////////////////
  // RULE1 - command write decode
  // RULE9 - same decode, second code
  assign cmd_write = wr_rise && !strobes.data_command_select && strobes.read_strobe;
  assign data_read = rd_rise && strobes.data_command_select && strobes.write_strobe;
  assign is_status_cmd = status_cmd(data_in);

  ////////////////////////////////////////////////////////////////////
  // Read sequencer
  always_comb begin
    state_nxt = state_r;
    sel_signal_nxt = sel_signal_r;
    data_out_nxt = data_out_r;
    if (soft_reset) begin
      state_nxt = RD_IDLE;
      data_out_nxt = DUMMY_BYTE;
    end else if (cmd_write) begin
      // RULE7 - no power state gating
      if (is_status_cmd) begin
        sel_signal_nxt = (data_in == CMD_READ_SIGNAL_MODE);
        // RULE6 - link mode skips dummy
        state_nxt = dsi_mode ? RD_STATUS : RD_DUMMY;
      end else begin
        state_nxt = RD_IDLE;
      end
    end else if (data_read) begin
      case (state_r)
        RD_DUMMY: begin
          // RULE2 - dummy byte first
          data_out_nxt = DUMMY_BYTE;
          state_nxt = RD_STATUS;
        end
        RD_STATUS: begin
          // RULE5 - further reads repeat status
          data_out_nxt = sel_signal_r ? signal_mode : image_mode;
          state_nxt = RD_STATUS;
        end
        RD_IDLE: begin
          data_out_nxt = data_out_r;
        end
        default: begin
          state_nxt = RD_IDLE;
        end
      endcase
    end
  end

  // RULE8 - image status zero at reset
  // RULE18 - signal status zero at reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= RD_IDLE;
      sel_signal_r <= 1'b0;
      data_out_r <= DUMMY_BYTE;
    end else begin
      state_r <= state_nxt;
      sel_signal_r <= sel_signal_nxt;
      data_out_r <= data_out_nxt;
    end
  end

  assign data_out = data_out_r;
  assign data_oe = !strobes.read_strobe && strobes.data_command_select &&
    (state_r != RD_IDLE || data_out_r != DUMMY_BYTE);

  ////////////////////////////////////////////////////////////////////
  // Command and read events seen by the checks
  sequence cmd_seen_s;
    cmd_write && is_status_cmd && !dsi_mode && !soft_reset;
  endsequence

  sequence link_cmd_s;
    cmd_write && is_status_cmd && dsi_mode && !soft_reset;
  endsequence

  sequence image_cmd_s;
    cmd_write && data_in == CMD_READ_IMAGE_MODE && !soft_reset;
  endsequence

  sequence signal_cmd_s;
    cmd_write && data_in == CMD_READ_SIGNAL_MODE && !soft_reset;
  endsequence

  sequence other_cmd_s;
    cmd_write && !is_status_cmd && !soft_reset;
  endsequence

  sequence first_read_s;
    state_r == RD_DUMMY && data_read && !cmd_write && !soft_reset;
  endsequence

  sequence status_read_s;
    state_r == RD_STATUS && data_read && !cmd_write && !soft_reset;
  endsequence

  sequence idle_read_s;
    state_r == RD_IDLE && data_read && !cmd_write && !soft_reset;
  endsequence

  // RULE2 - dummy read pending
  dummy_pending_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
    cmd_seen_s |=> state_r == RD_DUMMY)
    else $error("dummy read not pending");

  // RULE2 - dummy byte first
  dummy_first_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
    first_read_s |=> data_out == DUMMY_BYTE)
    else $error("first read not dummy");

  // RULE2 - status after dummy
  dummy_then_status_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
    first_read_s |=> state_r == RD_STATUS)
    else $error("status not next after dummy");

  // RULE2 - image byte selected
  image_select_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
    image_cmd_s |=> !sel_signal_r)
    else $error("image byte not selected");

  // RULE9 - signal byte selected
  signal_select_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE9
    signal_cmd_s |=> sel_signal_r)
    else $error("signal byte not selected");

  // RULE1 - other codes idle
  other_cmd_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE1
    other_cmd_s |=> state_r == RD_IDLE)
    else $error("other command left read pending");

  // RULE5 - status repeats
  status_repeat_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
    status_read_s |=> data_out == (sel_signal_r ? $past(signal_mode) : $past(image_mode)))
    else $error("status byte wrong");

  // RULE5 - status state kept
  status_stay_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
    status_read_s |=> state_r == RD_STATUS)
    else $error("status state left on read");

  // RULE5 - idle read holds
  idle_read_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
    idle_read_s |=> $stable(data_out))
    else $error("idle read changed data");

  // RULE5 - bus released
  oe_release_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
    strobes.read_strobe |-> !data_oe)
    else $error("data driven without read strobe");

  // RULE5 - status driven
  oe_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
    !strobes.read_strobe && strobes.data_command_select && state_r == RD_STATUS |-> data_oe)
    else $error("status read not driven");

  // RULE6 - link mode goes straight to status
  dsi_skip_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE6
    link_cmd_s |=> state_r == RD_STATUS)
    else $error("dummy not skipped on link");

  // RULE7 - accepted while sleeping
  sleep_accept_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE7
    cmd_write && is_status_cmd && sleep_in && !soft_reset |=> state_r != RD_IDLE)
    else $error("command refused in sleep");

  // RULE3 - scrolling reported
  scroll_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE3
    !soft_reset |-> image_mode[IM_SCROLL_BIT] == flags.scroll_on)
    else $error("scroll bit wrong");

  // RULE4 - inversion reported
  invert_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE4
    !soft_reset |-> image_mode[IM_INVERT_BIT] == flags.invert_on)
    else $error("inversion bit wrong");

  // RULE4 - reserved image bits zero
  image_resv_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE4
    (image_mode & 8'h5f) == 8'h00)
    else $error("reserved image bits set");

  // RULE10 - tearing enable reported
  te_on_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE10
    !soft_reset |-> signal_mode[SM_TE_ON_BIT] == flags.te_on)
    else $error("tearing enable bit wrong");

  // RULE11 - tearing mode reported
  te_mode_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE11
    !soft_reset |-> signal_mode[SM_TE_MODE_BIT] == flags.te_mode2)
    else $error("tearing mode bit wrong");

  // RULE12 - horizontal sync reported
  hsync_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE12
    !soft_reset |-> signal_mode[SM_HSYNC_BIT] == flags.hsync_on)
    else $error("horizontal sync bit wrong");

  // RULE13 - vertical sync reported
  vsync_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE13
    !soft_reset |-> signal_mode[SM_VSYNC_BIT] == flags.vsync_on)
    else $error("vertical sync bit wrong");

  // RULE14 - pixel clock reported
  pclk_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE14
    !soft_reset |-> signal_mode[SM_PCLK_BIT] == flags.pclk_on)
    else $error("pixel clock bit wrong");

  // RULE15 - data enable reported
  de_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE15
    !soft_reset |-> signal_mode[SM_DE_BIT] == flags.de_on)
    else $error("data enable bit wrong");

  // RULE16 - reserved signal bit zero
  signal_resv_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE16
    signal_mode[1] == 1'b0)
    else $error("reserved signal bit set");

  // RULE8 - soft reset clears image byte
  image_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE8
    soft_reset |-> image_mode == IMAGE_MODE_RESET)
    else $error("image byte not cleared");

  // RULE8 - soft reset idles sequencer
  soft_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE8
    soft_reset |=> state_r == RD_IDLE && data_out == DUMMY_BYTE)
    else $error("sequencer not idle after soft reset");

  // RULE18 - soft reset clears error bit
  signal_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE18
    soft_reset |=> !signal_mode[SM_DSI_ERR_BIT])
    else $error("error bit not cleared");

  // RULE18 - soft reset clears signal byte
  signal_soft_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE18
    soft_reset |-> signal_mode == SIGNAL_MODE_RESET)
    else $error("signal byte not cleared");

endmodule

// ---- host_model.sv ----
/*
 Host model for the status readback block: command writes and reads.
 Assumes it shares sys_clk with the device.
*/
`timescale 1ns/100ps
module host_model
  import status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] data_out,
  output bus_strobes_s strobes,
  output logic [7:0] data_in
);
  initial begin
    strobes = 3'h7;
    data_in = 8'h5a;
  end
  ////////////////////////////////////////
  // command write cycle
  task automatic cmd_write(input logic [7:0] code);
    @(posedge sys_clk) #1;
    strobes.data_command_select = 1'b0;
    data_in = code;
    strobes.write_strobe = 1'b0;
    @(posedge sys_clk) #1;
    strobes.write_strobe = 1'b1;
    @(posedge sys_clk) #1;
    strobes.data_command_select = 1'b1;
    data_in = ~code;
  endtask
  ////////////////////////////////////////
  // One read strobe cycle
  task automatic bus_read(output logic [7:0] value);
    @(posedge sys_clk) #1;
    strobes.read_strobe = 1'b0;
    @(posedge sys_clk) #1;
    strobes.read_strobe = 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk) #1;
    value = data_out;
  endtask
endmodule

// ---- display_mode_status_readback_bench.sv ----
/*
 Testbench for the status readback block, host model in front.
 Assumes the design and status_pkg are compiled first.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module display_mode_status_readback_bench
  import status_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic soft_reset = 1'b0;
  logic dsi_mode = 1'b0;
  logic sleep_in = 1'b0;
  logic dsi_error = 1'b0;
  disp_flags_s flags = '0;
  bus_strobes_s strobes;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe;
  int n_mismatch = 0;
  int check_count = 0;
  always #20 sys_clk = ~sys_clk;
  display_mode_status_readback display_mode_status_readback_i (
    .sys_clk(sys_clk), .resetn(resetn), .soft_reset(soft_reset),
    .strobes(strobes), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .dsi_mode(dsi_mode), .sleep_in(sleep_in),
    .flags(flags), .dsi_error(dsi_error)
  );
  host_model host_model_i (
    .sys_clk(sys_clk), .data_out(data_out), .strobes(strobes), .data_in(data_in)
  );
  ////////////////////////////////////////
  task automatic rd_chk(input logic [7:0] exp);
    logic [7:0] v;
    host_model_i.bus_read(v);
    `CHK(v, exp)
    `CHK(data_oe, 1'b0)
  endtask
  task automatic t_reset;
    host_model_i.cmd_write(CMD_READ_IMAGE_MODE);
    rd_chk(DUMMY_BYTE);
    rd_chk(8'h00);
    host_model_i.cmd_write(CMD_READ_SIGNAL_MODE);
    rd_chk(DUMMY_BYTE);
    rd_chk(8'h00);
    $display("test reset values done");
  endtask
  task automatic t_image;
    @(posedge sys_clk) #1;
    sleep_in = 1'b1;
    flags = 8'hc0;
    host_model_i.cmd_write(CMD_READ_IMAGE_MODE);
    rd_chk(DUMMY_BYTE);
    rd_chk(8'ha0);
    rd_chk(8'ha0);
    flags = 8'h40;
    host_model_i.cmd_write(CMD_READ_IMAGE_MODE);
    rd_chk(DUMMY_BYTE);
    rd_chk(8'h20);
    sleep_in = 1'b0;
    $display("test image mode done");
  endtask
  task automatic t_signal;
    for (int i = 0; i < 6; i++) begin
      flags = disp_flags_s'(8'h01 << i);
      host_model_i.cmd_write(CMD_READ_SIGNAL_MODE);
      rd_chk(DUMMY_BYTE);
      rd_chk(8'h04 << i);
    end
    flags = '0;
    @(posedge sys_clk) #1;
    dsi_error = 1'b1;
    @(posedge sys_clk) #1;
    dsi_error = 1'b0;
    host_model_i.cmd_write(CMD_READ_SIGNAL_MODE);
    rd_chk(DUMMY_BYTE);
    rd_chk(8'h01);
    $display("test signal mode done");
  endtask
  task automatic t_link;
    dsi_mode = 1'b1;
    host_model_i.cmd_write(CMD_READ_SIGNAL_MODE);
    rd_chk(8'h01);
    host_model_i.cmd_write(8'h0b);
    rd_chk(8'h01);
    dsi_mode = 1'b0;
    $display("test link mode done");
  endtask
  task automatic t_soft;
    @(posedge sys_clk) #1;
    soft_reset = 1'b1;
    @(posedge sys_clk) #1;
    soft_reset = 1'b0;
    host_model_i.cmd_write(CMD_READ_SIGNAL_MODE);
    rd_chk(DUMMY_BYTE);
    rd_chk(8'h00);
    $display("test soft reset done");
  endtask
  task automatic t_hard;
    @(posedge sys_clk) #1;
    dsi_error = 1'b1;
    @(posedge sys_clk) #1;
    dsi_error = 1'b0;
    host_model_i.cmd_write(CMD_READ_IMAGE_MODE);
    rd_chk(DUMMY_BYTE);
    @(posedge sys_clk) #1;
    resetn = 1'b0;
    @(posedge sys_clk) #1;
    `CHK(data_out, DUMMY_BYTE)
    resetn = 1'b1;
    host_model_i.cmd_write(CMD_READ_SIGNAL_MODE);
    rd_chk(DUMMY_BYTE);
    rd_chk(8'h00);
    host_model_i.cmd_write(CMD_READ_IMAGE_MODE);
    rd_chk(DUMMY_BYTE);
    rd_chk(8'h00);
    $display("test hardware reset done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 resetn = 1'b1;
    t_reset();
    t_image();
    t_signal();
    t_link();
    t_soft();
    t_hard();
    tally_and_finish();
  end
endmodule
